// ==== mbdc_pkg.sv ====
`default_nettype none
package mbdc_pkg;
  // Register offsets on the serial host bus
  localparam logic [7:0] ADDR_CMD_DATA  = 8'h48;
  localparam logic [7:0] ADDR_CMD_WORD  = 8'h49;
  localparam logic [7:0] ADDR_CMD_CTRL  = 8'h4a;
  localparam logic [7:0] ADDR_CMD_LEVEL = 8'h4b;
  localparam logic [7:0] ADDR_RX_DATA   = 8'h4c;
  localparam logic [7:0] ADDR_RX_LEVEL  = 8'h4f;
  localparam logic [7:0] ADDR_FIFO_CTRL = 8'h50;
  localparam logic [7:0] ADDR_RX_TRACK  = 8'h66;
  localparam logic [7:0] ADDR_MODE      = 8'h6b;
  localparam logic [7:0] ADDR_STATUS    = 8'h7e;

  // Field positions
  localparam int FLUSH_CMD_BIT    = 7;
  localparam int FLUSH_RX_BIT     = 15;
  localparam int MODE_LSB         = 0;
  localparam int TRACK_DC_LSB     = 0;
  localparam int TRACK_TIMING_LSB = 4;
  localparam int STAT_UNDERRUN    = 2;
  localparam int STAT_OVERFLOW    = 3;
  localparam int STAT_SYNC        = 4;
  localparam int STAT_CMD_DONE    = 8;
  localparam int STAT_TAIL_SENT   = 9;

  // Encodings
  localparam logic [1:0] MODE_IDLE  = 2'h0;
  localparam logic [1:0] MODE_RX    = 2'h1;
  localparam logic [1:0] MODE_TX    = 2'h2;
  localparam logic [1:0] TRACK_AUTO = 2'h3;
  localparam logic [3:0] OP_BLOCK   = 4'h1;
  localparam logic [3:0] OP_END     = 4'hf;

  // Reset values and fixed counts
  localparam logic [4:0]  BLOCK_RST   = 5'h08;
  localparam logic [15:0] STATUS_RST  = 16'h0000;
  localparam logic [7:0]  FILL_BYTE   = 8'h00;
  localparam logic [3:0]  SYNC_BYTES  = 4'h2;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_PRE    = 7'b0000010,
    ST_SYNC   = 7'b0000100,
    ST_DATA   = 7'b0001000,
    ST_TAIL   = 7'b0010000,
    ST_SEARCH = 7'b0100000,
    ST_RECV   = 7'b1000000
  } mbdc_state_t;
endpackage : mbdc_pkg
`default_nettype wire

// ==== mbdc_bus_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface mbdc_bus_if;
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport slave (output wr_stb, output rd_stb, output addr, output wdata,
                 input rdata);
  modport core  (input wr_stb, input rd_stb, input addr, input wdata,
                 output rdata);
endinterface : mbdc_bus_if
`default_nettype wire

// ==== mbdc_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module mbdc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int LW    = $clog2(DEPTH) + 1
) (
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          flush_in,
  input  wire logic          push_in,
  input  wire logic [W-1:0]  wdata_in,
  input  wire logic          pop_in,
  output logic      [W-1:0]  rdata_out,
  output logic               full_out,
  output logic               empty_out,
  output logic      [LW-1:0] level_out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [LW-1:0] lvl_q;
  logic          do_push;
  logic          do_pop;

  assign full_out  = (lvl_q == LW'(DEPTH));
  assign empty_out = (lvl_q == '0);
  assign level_out = lvl_q;
  assign rdata_out = mem[rp_q];
  assign do_push   = push_in && !full_out;
  assign do_pop    = pop_in && !empty_out;

  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[wp_q] <= wdata_in;
    end
  end

  // Flush beats a coincident push or pop
  always_ff @(posedge clk_in) begin
    if (rst_in || flush_in) begin
      wp_q  <= '0;
      rp_q  <= '0;
      lvl_q <= '0;
    end else begin
      if (do_push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      lvl_q <= lvl_q + LW'(do_push) - LW'(do_pop);
    end
  end
endmodule : mbdc_fifo
`default_nettype wire

// ==== mbdc_spi_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module mbdc_spi_slave (
  input  wire logic  clk_in,
  input  wire logic  rst_in,
  input  wire logic  sclk_in,
  input  wire logic  cs_n_in,
  input  wire logic  cdata_in,
  output logic       rdata_out,
  mbdc_bus_if.slave  bus
);
  logic [2:0]  sclk_q;
  logic [1:0]  cs_q;
  logic [1:0]  cd_q;
  logic [4:0]  bits_q;
  logic [22:0] shin_q;
  logic [15:0] shout_q;
  logic        reading_q;
  logic        rise;
  logic        fall;
  logic [7:0]  addr_now;
  logic        is_read;

  // Bit 0 of each chain is the metastable stage, read only by bit 1
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sclk_q <= 3'h0;
      cs_q   <= 2'h3;
      cd_q   <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk_in};
      cs_q   <= {cs_q[0], cs_n_in};
      cd_q   <= {cd_q[0], cdata_in};
    end
  end

  assign rise     = sclk_q[1] && !sclk_q[2] && !cs_q[1];
  assign fall     = !sclk_q[1] && sclk_q[2] && !cs_q[1];
  assign addr_now = {shin_q[6:0], cd_q[1]};
  assign is_read  = (addr_now == mbdc_pkg::ADDR_STATUS)
                 || (addr_now == mbdc_pkg::ADDR_RX_DATA)
                 || (addr_now == mbdc_pkg::ADDR_RX_LEVEL)
                 || (addr_now == mbdc_pkg::ADDR_CMD_LEVEL);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bits_q     <= 5'h00;
      shin_q     <= '0;
      reading_q  <= 1'b0;
      bus.wr_stb <= 1'b0;
      bus.rd_stb <= 1'b0;
      bus.addr   <= 8'h00;
      bus.wdata  <= 16'h0000;
    end else begin
      bus.wr_stb <= 1'b0;
      bus.rd_stb <= 1'b0;
      if (cs_q[1]) begin
        bits_q    <= 5'h00;
        reading_q <= 1'b0;
      end else if (rise) begin
        shin_q <= {shin_q[21:0], cd_q[1]};
        bits_q <= bits_q + 5'h01;
        if (bits_q == 5'h07) begin
          bus.addr   <= addr_now;
          reading_q  <= is_read;
          bus.rd_stb <= is_read;
        end
        if (bits_q == 5'h17 && !reading_q) begin
          bus.wdata  <= {shin_q[14:0], cd_q[1]};
          bus.wr_stb <= 1'b1;
        end
      end
    end
  end

  // Read word is latched in the strobe cycle, before the core pops
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shout_q <= 16'h0000;
    end else if (bus.rd_stb) begin
      shout_q <= bus.rdata;
    end else if (fall && reading_q && bits_q >= 5'h09) begin
      shout_q <= {shout_q[14:0], 1'b0};
    end
  end

  assign rdata_out = shout_q[15];
endmodule : mbdc_spi_slave
`default_nettype wire

// ==== mbdc_top.sv ====
// What this block does
// - Writing 0x0080 to FIFO control discards old command FIFO contents.
// - Control byte 0x18 sets eight-byte transmit blocks; then more is asked.
// - Mode 0x0042 starts transmit: preamble, frame sync, then queued data.
// - Status bit 8 sets when a transmit block has left the FIFO.
// - Command word 0xF000 ends the burst with tail bits, not an error.
// - Status bit 9 sets only after data and tail bits are modulated.
// - After tail sent, a mode write changes mode or starts a new burst.
// - Writing 0x8000 to FIFO control flushes the receive FIFO.
// - Command word 0x1400 delivers receive data in repeating four-byte blocks.
// - Writing 0x0033 to tracking enables auto dc offset and timing tracking.
// - Mode 0x0401 starts sync search; data flows only after sync.
// - In receive, status bit 8 sets when four bytes are readable.
// - A mode write during receive stops it or restarts the sync search.
// - Reading status clears all its flags after the address phase.
`timescale 1ns/1ps
`default_nettype none
module mbdc_top #(
  parameter int         CMD_DEPTH  = 16,
  parameter int         RX_DEPTH   = 16,
  parameter int         PRE_BYTES  = 4,
  parameter int         TAIL_BYTES = 1,
  parameter logic [7:0]  PRE_BYTE  = 8'h55,
  parameter logic [7:0]  TAIL_BYTE = 8'h00,
  // Arbitrary sync pattern value
  parameter logic [15:0] SYNC_WORD = 16'h3c5a
) (
  input  wire logic       CLK_IN,
  input  wire logic       RST_IN,
  input  wire logic       SCLK_IN,
  input  wire logic       CS_N_IN,
  input  wire logic       CDATA_IN,
  output logic            RDATA_OUT,
  input  wire logic       TX_REQ_IN,
  output logic [7:0]      TX_BYTE_OUT,
  output logic            TX_VALID_OUT,
  input  wire logic       RX_SYNC_IN,
  input  wire logic [7:0] RX_BYTE_IN,
  input  wire logic       RX_VALID_IN,
  output logic            TRACK_DC_AUTO_OUT,
  output logic            TRACK_TIMING_AUTO_OUT
);
  localparam int CLW = $clog2(CMD_DEPTH) + 1;
  localparam int RLW = $clog2(RX_DEPTH) + 1;
  localparam logic [7:0] FILL_BYTE_C = mbdc_pkg::FILL_BYTE;

  mbdc_bus_if bus ();

  mbdc_pkg::mbdc_state_t state_q;
  logic [3:0]     cnt_q;
  logic [4:0]     blk_size_q;
  logic [4:0]     blk_cnt_q;
  logic [15:0]    status_q;
  logic           pend_q;
  logic [15:0]    stat_set;
  logic [8:0]     cmd_head;
  logic [8:0]     cmd_wdata;
  logic           cmd_push;
  logic           cmd_pop;
  logic           cmd_empty;
  logic           cmd_full;
  logic [CLW-1:0] cmd_level;
  logic [7:0]     rx_head;
  logic           rx_push;
  logic           rx_pop;
  logic           rx_empty;
  logic           rx_full;
  logic [RLW-1:0] rx_level;
  logic           wr;
  logic           mode_wr;
  logic           mode_take;
  logic [1:0]     new_mode;
  logic           tx_busy;
  logic           rx_on;
  logic           head_ctrl;
  logic [3:0]     head_op;
  logic           ctrl_pop;
  logic           data_pop;
  logic           req_any;
  logic           emit;
  logic [7:0]     emit_byte;
  logic           underrun;
  logic           tail_done;
  logic           served;
  logic           rx_take;
  logic           byte_evt;
  logic           blk_last;
  logic           stat_rd;

  mbdc_spi_slave u_slave (
    .clk_in    (CLK_IN),
    .rst_in    (RST_IN),
    .sclk_in   (SCLK_IN),
    .cs_n_in   (CS_N_IN),
    .cdata_in  (CDATA_IN),
    .rdata_out (RDATA_OUT),
    .bus       (bus.slave)
  );

  assign wr        = bus.wr_stb;
  assign mode_wr   = wr && bus.addr == mbdc_pkg::ADDR_MODE;
  assign new_mode  = bus.wdata[mbdc_pkg::MODE_LSB +: 2];
  assign tx_busy   = state_q inside {mbdc_pkg::ST_PRE, mbdc_pkg::ST_SYNC,
                                     mbdc_pkg::ST_DATA, mbdc_pkg::ST_TAIL};
  assign rx_on     = state_q inside {mbdc_pkg::ST_SEARCH, mbdc_pkg::ST_RECV};
  // Start of a new burst is dropped while the current one is still running
  assign mode_take = mode_wr && !(new_mode == mbdc_pkg::MODE_TX && tx_busy);

  // Command FIFO entries carry a control flag above the byte
  always_comb begin
    cmd_push  = 1'b0;
    cmd_wdata = {1'b0, bus.wdata[7:0]};
    if (wr) begin
      case (bus.addr)
        mbdc_pkg::ADDR_CMD_DATA: cmd_push = 1'b1;
        mbdc_pkg::ADDR_CMD_CTRL: begin
          cmd_push  = 1'b1;
          cmd_wdata = {1'b1, bus.wdata[7:0]};
        end
        mbdc_pkg::ADDR_CMD_WORD: begin
          cmd_push  = 1'b1;
          cmd_wdata = {1'b1, bus.wdata[15:8]};
        end
        default: cmd_push = 1'b0;
      endcase
    end
  end

  mbdc_fifo #(.W(9), .DEPTH(CMD_DEPTH)) u_cmd_fifo (
    .clk_in    (CLK_IN),
    .rst_in    (RST_IN),
    .flush_in  (wr && bus.addr == mbdc_pkg::ADDR_FIFO_CTRL
                && bus.wdata[mbdc_pkg::FLUSH_CMD_BIT]),
    .push_in   (cmd_push),
    .wdata_in  (cmd_wdata),
    .pop_in    (cmd_pop),
    .rdata_out (cmd_head),
    .full_out  (cmd_full),
    .empty_out (cmd_empty),
    .level_out (cmd_level)
  );

  mbdc_fifo #(.W(8), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .clk_in    (CLK_IN),
    .rst_in    (RST_IN),
    .flush_in  (wr && bus.addr == mbdc_pkg::ADDR_FIFO_CTRL
                && bus.wdata[mbdc_pkg::FLUSH_RX_BIT]),
    .push_in   (rx_push),
    .wdata_in  (RX_BYTE_IN),
    .pop_in    (rx_pop),
    .rdata_out (rx_head),
    .full_out  (rx_full),
    .empty_out (rx_empty),
    .level_out (rx_level)
  );

  assign head_ctrl = cmd_head[8];
  assign head_op   = cmd_head[7:4];
  // End command waits in the queue until the data ahead of it is sent
  assign ctrl_pop  = !cmd_empty && head_ctrl
                  && ((tx_busy && state_q != mbdc_pkg::ST_TAIL
                       && head_op != mbdc_pkg::OP_END)
                   || (state_q == mbdc_pkg::ST_DATA)
                   || rx_on);
  assign req_any   = TX_REQ_IN || pend_q;
  assign data_pop  = state_q == mbdc_pkg::ST_DATA && req_any
                  && !cmd_empty && !head_ctrl;
  assign cmd_pop   = ctrl_pop || data_pop;

  // Byte handed to the modulator for each request
  always_comb begin
    emit      = 1'b0;
    emit_byte = FILL_BYTE_C;
    underrun  = 1'b0;
    tail_done = 1'b0;
    if (req_any) begin
      case (state_q)
        mbdc_pkg::ST_PRE: begin
          emit      = 1'b1;
          emit_byte = PRE_BYTE;
        end
        mbdc_pkg::ST_SYNC: begin
          emit      = 1'b1;
          emit_byte = (cnt_q == 4'h0) ? SYNC_WORD[15:8] : SYNC_WORD[7:0];
        end
        mbdc_pkg::ST_DATA: begin
          if (cmd_empty) begin
            emit     = 1'b1;
            underrun = 1'b1;
          end else if (!head_ctrl) begin
            emit      = 1'b1;
            emit_byte = cmd_head[7:0];
          end
        end
        mbdc_pkg::ST_TAIL: begin
          if (cnt_q < 4'(TAIL_BYTES)) begin
            emit      = 1'b1;
            emit_byte = TAIL_BYTE;
          end else begin
            tail_done = 1'b1;
          end
        end
        default: emit = 1'b0;
      endcase
    end
    served = emit || tail_done;
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= req_any && !served && tx_busy && !mode_take;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      TX_BYTE_OUT  <= 8'h00;
      TX_VALID_OUT <= 1'b0;
    end else begin
      TX_VALID_OUT <= emit && !mode_take;
      if (emit) begin
        TX_BYTE_OUT <= emit_byte;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state_q <= mbdc_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
    end else if (mode_take) begin
      cnt_q <= 4'h0;
      case (new_mode)
        mbdc_pkg::MODE_TX: state_q <= mbdc_pkg::ST_PRE;
        mbdc_pkg::MODE_RX: state_q <= mbdc_pkg::ST_SEARCH;
        default:           state_q <= mbdc_pkg::ST_IDLE;
      endcase
    end else begin
      case (state_q)
        mbdc_pkg::ST_PRE: begin
          if (served) begin
            if (cnt_q == 4'(PRE_BYTES - 1)) begin
              state_q <= mbdc_pkg::ST_SYNC;
              cnt_q   <= 4'h0;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        mbdc_pkg::ST_SYNC: begin
          if (served) begin
            if (cnt_q == mbdc_pkg::SYNC_BYTES - 4'h1) begin
              state_q <= mbdc_pkg::ST_DATA;
              cnt_q   <= 4'h0;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        mbdc_pkg::ST_DATA: begin
          if (ctrl_pop && head_op == mbdc_pkg::OP_END) begin
            state_q <= mbdc_pkg::ST_TAIL;
          end
        end
        mbdc_pkg::ST_TAIL: begin
          if (tail_done) begin
            state_q <= mbdc_pkg::ST_IDLE;
          end else if (served) begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        mbdc_pkg::ST_SEARCH: begin
          if (RX_SYNC_IN) begin
            state_q <= mbdc_pkg::ST_RECV;
          end
        end
        default: cnt_q <= cnt_q;
      endcase
    end
  end

  // Receive bytes are taken only once sync has been found
  assign rx_take  = state_q == mbdc_pkg::ST_RECV && RX_VALID_IN;
  assign rx_push  = rx_take && !rx_full;
  assign byte_evt = data_pop || rx_take;
  assign blk_last = blk_cnt_q + 5'h01 == blk_size_q;

  // Block size: count 0 stands for sixteen bytes
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      blk_size_q <= mbdc_pkg::BLOCK_RST;
      blk_cnt_q  <= 5'h00;
    end else if (mode_take) begin
      blk_cnt_q <= 5'h00;
    end else if (ctrl_pop && head_op == mbdc_pkg::OP_BLOCK) begin
      blk_size_q <= {cmd_head[3:0] == 4'h0, cmd_head[3:0]};
      blk_cnt_q  <= 5'h00;
    end else if (byte_evt) begin
      blk_cnt_q <= blk_last ? 5'h00 : blk_cnt_q + 5'h01;
    end
  end

  always_comb begin
    stat_set = 16'h0000;
    stat_set[mbdc_pkg::STAT_CMD_DONE]  = byte_evt && blk_last;
    stat_set[mbdc_pkg::STAT_TAIL_SENT] = tail_done && !mode_take;
    stat_set[mbdc_pkg::STAT_UNDERRUN]  = underrun && !mode_take;
    stat_set[mbdc_pkg::STAT_OVERFLOW]  = rx_take && rx_full;
    stat_set[mbdc_pkg::STAT_SYNC]      = state_q == mbdc_pkg::ST_SEARCH
                                      && RX_SYNC_IN && !mode_take;
  end

  // A new event in the clearing cycle survives the clear
  assign stat_rd = bus.rd_stb && bus.addr == mbdc_pkg::ADDR_STATUS;
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      status_q <= mbdc_pkg::STATUS_RST;
    end else begin
      status_q <= (stat_rd ? 16'h0000 : status_q) | stat_set;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      TRACK_DC_AUTO_OUT     <= 1'b0;
      TRACK_TIMING_AUTO_OUT <= 1'b0;
    end else if (wr && bus.addr == mbdc_pkg::ADDR_RX_TRACK) begin
      TRACK_DC_AUTO_OUT     <= bus.wdata[mbdc_pkg::TRACK_DC_LSB +: 2]
                               == mbdc_pkg::TRACK_AUTO;
      TRACK_TIMING_AUTO_OUT <= bus.wdata[mbdc_pkg::TRACK_TIMING_LSB +: 2]
                               == mbdc_pkg::TRACK_AUTO;
    end
  end

  // Each read of the data location hands out one byte
  assign rx_pop = bus.rd_stb && bus.addr == mbdc_pkg::ADDR_RX_DATA;
  always_comb begin
    case (bus.addr)
      mbdc_pkg::ADDR_STATUS:    bus.rdata = status_q;
      mbdc_pkg::ADDR_RX_DATA:   bus.rdata = {8'h00, rx_head};
      mbdc_pkg::ADDR_RX_LEVEL:  bus.rdata = 16'(rx_level);
      mbdc_pkg::ADDR_CMD_LEVEL: bus.rdata = 16'(cmd_level);
      default:                  bus.rdata = 16'h0000;
    endcase
  end

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  sequence s_mode_wr(logic [1:0] m);
    mode_wr && new_mode == m;
  endsequence

  sequence s_fctl_wr(int b);
    wr && bus.addr == mbdc_pkg::ADDR_FIFO_CTRL && bus.wdata[b];
  endsequence

  a_tx_start_pre: assert property (
    s_mode_wr(mbdc_pkg::MODE_TX) and (state_q == mbdc_pkg::ST_IDLE)
    |=> state_q == mbdc_pkg::ST_PRE && cnt_q == 4'h0)
    else $error("transmit start did not enter preamble");
  a_tx_busy_hold: assert property (
    s_mode_wr(mbdc_pkg::MODE_TX) and (state_q == mbdc_pkg::ST_DATA)
    |=> state_q != mbdc_pkg::ST_PRE)
    else $error("burst restarted before tail sent");
  a_cmd_flush: assert property (
    s_fctl_wr(mbdc_pkg::FLUSH_CMD_BIT) |=> cmd_empty)
    else $error("command FIFO not flushed");
  a_rx_flush: assert property (
    s_fctl_wr(mbdc_pkg::FLUSH_RX_BIT) |=> rx_empty)
    else $error("receive FIFO not flushed");
  a_blk_bound: assert property (
    blk_cnt_q < blk_size_q)
    else $error("block count passed block size");
  a_blk_done: assert property (
    data_pop && blk_last && !stat_rd |=> status_q[mbdc_pkg::STAT_CMD_DONE])
    else $error("transmit block done not flagged");
  a_rx_blk_done: assert property (
    rx_take && blk_last ##1 !stat_rd [*2]
    |-> status_q[mbdc_pkg::STAT_CMD_DONE])
    else $error("receive block done not flagged");
  a_tail_order: assert property (
    $rose(status_q[mbdc_pkg::STAT_TAIL_SENT])
    |-> $past(state_q) == mbdc_pkg::ST_TAIL && $past(cnt_q) == 4'(TAIL_BYTES))
    else $error("tail flag before tail bits sent");
  a_end_to_tail: assert property (
    ctrl_pop && head_op == mbdc_pkg::OP_END && !mode_take
    |=> state_q == mbdc_pkg::ST_TAIL
        ##1 !$rose(status_q[mbdc_pkg::STAT_UNDERRUN]))
    else $error("end command did not start tail");
  a_rx_gate: assert property (
    rx_push |-> state_q == mbdc_pkg::ST_RECV)
    else $error("receive data before sync");
  a_rx_restart: assert property (
    s_mode_wr(mbdc_pkg::MODE_RX) and (state_q == mbdc_pkg::ST_RECV)
    |=> state_q == mbdc_pkg::ST_SEARCH)
    else $error("receive did not restart sync search");
  a_stat_clear: assert property (
    stat_rd |=> status_q == $past(stat_set))
    else $error("status not cleared by read");
endmodule : mbdc_top
`default_nettype wire

// ==== mbdc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module mbdc_host (
  input  wire logic clk_in,
  input  wire logic rdata_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      cdata_out
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    cdata_out = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk_in);
  endtask : idle

  // Halves of 5 cycles leave room for the 2-flop sync
  task automatic xfer(input logic [7:0] a, input logic [15:0] w,
                      output logic [15:0] r);
    logic [23:0] sh;
    sh = {a, w};
    r = 16'h0000;
    cs_n_out = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      cdata_out = sh[i];
      idle(5);
      if (i < 16) r[i] = rdata_in;
      sclk_out = 1'b1;
      idle(5);
      sclk_out = 1'b0;
    end
    idle(5);
    cs_n_out = 1'b1;
    // Released line must not keep showing the last bit
    cdata_out = ~cdata_out;
    idle(8);
  endtask : xfer
endmodule : mbdc_host
`default_nettype wire

// ==== modem_burst_data_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module modem_burst_data_control_tb;
  logic        clk, rst, req, sync, rvld, txv, sclk, cs_n, cdata;
  logic        rdo, dc, tm;
  logic [7:0]  rbyte, txb;
  logic [15:0] rd;
  logic [31:0] v;
  logic [7:0]  q[$];
  int          error_cnt, num_checks, seed;

  mbdc_top mbdc_top_inst (
    .CLK_IN(clk), .RST_IN(rst), .SCLK_IN(sclk), .CS_N_IN(cs_n),
    .CDATA_IN(cdata), .RDATA_OUT(rdo), .TX_REQ_IN(req),
    .TX_BYTE_OUT(txb), .TX_VALID_OUT(txv), .RX_SYNC_IN(sync),
    .RX_BYTE_IN(rbyte), .RX_VALID_IN(rvld),
    .TRACK_DC_AUTO_OUT(dc), .TRACK_TIMING_AUTO_OUT(tm));
  mbdc_host mbdc_host_inst (.clk_in(clk), .rdata_in(rdo),
    .sclk_out(sclk), .cs_n_out(cs_n), .cdata_out(cdata));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic bus(input logic [7:0] a, input logic [15:0] w);
    mbdc_host_inst.xfer(a, w, rd);
  endtask : bus

  task automatic pulse_req;
    @(negedge clk);
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
  endtask : pulse_req

  // Valid lasts one cycle, so look at every cycle
  task automatic take(input logic [7:0] exp);
    int n;
    n = 0;
    pulse_req();
    while (txv !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (txv !== 1'b1) begin
      error_cnt++;
      stop_test();
    end
    check({8'h00, txb}, {8'h00, exp});
  endtask : take

  task automatic poll(input int b);
    int n;
    n = 0;
    rd = 16'h0000;
    while (rd[b] !== 1'b1 && n < 20) begin
      bus(mbdc_pkg::ADDR_STATUS, 16'h0000);
      n++;
    end
    if (rd[b] !== 1'b1) begin
      error_cnt++;
      stop_test();
    end
    num_checks++;
  endtask : poll

  task automatic push(input logic [7:0] b);
    @(negedge clk);
    rbyte = b;
    rvld = 1'b1;
    @(negedge clk);
    rvld = 1'b0;
    rbyte = ~b;
  endtask : push

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    error_cnt = 0;
    num_checks = 0;
    seed = 33;
    rst = 1'b1;
    req = 1'b0;
    sync = 1'b0;
    rvld = 1'b0;
    rbyte = 8'h00;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check({14'h0, dc, tm}, 16'h0000);
    // Stale byte that the flush has to remove
    bus(mbdc_pkg::ADDR_CMD_DATA, 16'h00e7);
    bus(mbdc_pkg::ADDR_FIFO_CTRL, 16'h0080);
    bus(mbdc_pkg::ADDR_CMD_CTRL, 16'h0018);
    q = {8'h55, 8'h55, 8'h55, 8'h55, 8'h3c, 8'h5a};
    repeat (8) begin
      v = $random(seed);
      q.push_back(v[7:0]);
      bus(mbdc_pkg::ADDR_CMD_DATA, {8'h00, v[7:0]});
    end
    bus(mbdc_pkg::ADDR_CMD_LEVEL, 16'h0000);
    check(rd, 16'h0009);
    bus(mbdc_pkg::ADDR_MODE, 16'h0042);
    repeat (13) take(q.pop_front());
    // Restart while data flows must be ignored
    bus(mbdc_pkg::ADDR_MODE, 16'h0042);
    bus(mbdc_pkg::ADDR_STATUS, 16'h0000);
    check({15'h0, rd[8]}, 16'h0000);
    take(q.pop_front());
    poll(8);
    bus(mbdc_pkg::ADDR_CMD_WORD, 16'hf000);
    take(8'h00);
    bus(mbdc_pkg::ADDR_STATUS, 16'h0000);
    check({14'h0, rd[9], rd[2]}, 16'h0000);
    pulse_req();
    poll(9);
    check({15'h0, rd[2]}, 16'h0000);
    bus(mbdc_pkg::ADDR_MODE, 16'h0042);
    take(8'h55);
    bus(mbdc_pkg::ADDR_MODE, 16'h0000);
    bus(mbdc_pkg::ADDR_FIFO_CTRL, 16'h8000);
    bus(mbdc_pkg::ADDR_CMD_WORD, 16'h1400);
    bus(mbdc_pkg::ADDR_RX_TRACK, 16'h0033);
    check({14'h0, dc, tm}, 16'h0003);
    bus(mbdc_pkg::ADDR_MODE, 16'h0401);
    push(8'ha5);
    bus(mbdc_pkg::ADDR_RX_LEVEL, 16'h0000);
    check(rd, 16'h0000);
    @(negedge clk);
    sync = 1'b1;
    @(negedge clk);
    sync = 1'b0;
    repeat (2) begin
      repeat (4) begin
        v = $random(seed);
        q.push_back(v[7:0]);
        push(v[7:0]);
      end
      poll(8);
      repeat (4) begin
        bus(mbdc_pkg::ADDR_RX_DATA, 16'h0000);
        check({8'h00, rd[7:0]}, {8'h00, q.pop_front()});
      end
      bus(mbdc_pkg::ADDR_STATUS, 16'h0000);
      check({15'h0, rd[8]}, 16'h0000);
    end
    push(8'h3c);
    bus(mbdc_pkg::ADDR_FIFO_CTRL, 16'h8000);
    bus(mbdc_pkg::ADDR_RX_LEVEL, 16'h0000);
    check(rd, 16'h0000);
    bus(mbdc_pkg::ADDR_MODE, 16'h0401);
    push(8'h77);
    bus(mbdc_pkg::ADDR_RX_LEVEL, 16'h0000);
    check(rd, 16'h0000);
    stop_test();
  end
endmodule : modem_burst_data_control_tb
`default_nettype wire
